// ---- dv/tb_top.sv ----
/*
 * Self-checking bench of the result page: drives the converter side,
 * drives the host model, and checks read words against a model array.
 * Assumes the page answers one cycle after each strobe.
 */
`timescale 1ns/10ps
`include "trp_defs.svh"

module tb_top
    import trp_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clock;         // 25 MHz
    logic        reset_n;       // Synchronous, active low
    logic        conv_valid;    // Converter strobe
    logic [5:0]  conv_select;   // Quantity offset
    logic [11:0] conv_result;   // Conversion value
    wire  logic  cmd_valid;
    wire  logic [15:0] cmd_word;
    wire  logic  word_strobe;
    wire  logic [15:0] write_word;
    logic [15:0] read_data;
    logic        read_valid, page_hit, other_page, reserved_page, command_error;
    logic [15:0] mdl [64];      // Expected page contents
    logic [15:0] expq [$];      // Expected read words, oldest first
    logic [11:0] v;             // Random conversion value
    int          error_cnt = 0;
    int          n_tests   = 0;
    localparam logic [5:0] OFFS [9] = '{
        `TRP_OFF_HORIZONTAL_POSITION_RESULT, `TRP_OFF_VERTICAL_POSITION_RESULT,
        `TRP_OFF_TOUCH_PRESSURE_ONE_RESULT, `TRP_OFF_TOUCH_PRESSURE_TWO_RESULT,
        `TRP_OFF_SUPPLY_CELL_VOLTAGE_RESULT, `TRP_OFF_AUXILIARY_INPUT_ONE_RESULT,
        `TRP_OFF_AUXILIARY_INPUT_TWO_RESULT, `TRP_OFF_THERMAL_SENSE_ONE_RESULT,
        `TRP_OFF_THERMAL_SENSE_TWO_RESULT};

    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    trp_result_page u_dut (.clock(clock), .reset_n(reset_n), .conv_valid(conv_valid),
        .conv_select(conv_select), .conv_result(conv_result), .cmd_valid(cmd_valid),
        .cmd_word(cmd_word), .word_strobe(word_strobe), .write_word(write_word),
        .read_data(read_data), .read_valid(read_valid), .page_hit(page_hit),
        .other_page(other_page), .reserved_page(reserved_page), .command_error(command_error));

    trp_host_model u_host (.clock(clock), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .word_strobe(word_strobe), .write_word(write_word));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Monitor: every read word pops the oldest note; a stray one is an error
    always @(negedge clock) begin
        if (read_valid === 1'b1) begin
            if (expq.size() == 0) chk("read_valid", 16'h0000, 16'h0001);
            else chk("read_data", expq.pop_front(), read_data);
        end
    end

    // Converter strobe; the stale value is inverted afterwards
    task automatic conv(input logic [5:0] sel, input logic [11:0] val);
        @(negedge clock);
        conv_valid  = 1'b1;
        conv_select = sel;
        conv_result = val;
        @(negedge clock);
        conv_valid  = 1'b0;
        conv_result = ~val;
    endtask

    // Read session of n words from an offset of the data page
    task automatic rd(input logic [5:0] off, input int n);
        int p;
        p = off;
        u_host.send_cmd(1'b1, `TRP_PAGE_DATA, off, 5'h00);
        chk("page_hit", 16'h0001, 16'(page_hit));
        chk("command_error", 16'h0000, 16'(command_error));
        for (int i = 0; i < n; i++) begin
            expq.push_back(p <= 63 ? mdl[p] : `TRP_READ_PAST_END);
            p++;
            u_host.send_word(16'($urandom));
        end
        repeat (2) @(negedge clock);
        chk("words_left", 16'h0000, 16'(expq.size()));
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles of the run
    initial begin
        #(40 * 20000);
        error_cnt++;
        tally_and_finish;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hDA75));
        reset_n     = 1'b0;
        conv_valid  = 1'b0;
        conv_select = 6'h00;
        conv_result = 12'h000;
        for (int i = 0; i < 64; i++) mdl[i] = 16'h0000;
        repeat (12) @(negedge clock);
        reset_n = 1'b1;
        rd(6'h00, 12);
        // Every quantity with a random value, plus an unknown offset
        for (int i = 0; i < 9; i++) begin
            v = 12'($urandom);
            conv(OFFS[i], v);
            mdl[OFFS[i]] = {4'h0, v};
        end
        conv(6'h04, 12'hFFF);
        rd(6'h00, 11);
        rd(6'h00, 11);
        // Write session of all ones must not land
        u_host.send_cmd(1'b0, `TRP_PAGE_DATA, 6'h00, 5'h00);
        repeat (11) u_host.send_word(16'hFFFF);
        rd(6'h00, 11);
        rd(6'h3E, 5);
        // Other and reserved pages open no data session
        for (int p = 1; p < 16; p++) begin
            u_host.send_cmd(1'b1, 4'(p), 6'h00, 5'h00);
            chk("other_page", 16'(p < 4), 16'(other_page));
            chk("reserved_page", 16'(p > 3), 16'(reserved_page));
            chk("page_hit", 16'h0000, 16'(page_hit));
            u_host.send_word(16'h1234);
        end
        // Nonzero tail is refused
        u_host.send_cmd(1'b1, `TRP_PAGE_DATA, 6'h00, 5'h01);
        chk("command_error", 16'h0001, 16'(command_error));
        u_host.send_word(16'h0000);
        // Reset in mid-run clears every result
        @(negedge clock);
        reset_n = 1'b0;
        @(negedge clock);
        reset_n = 1'b1;
        for (int i = 0; i < 64; i++) mdl[i] = 16'h0000;
        rd(6'h00, 11);
        tally_and_finish;
    end
endmodule

// ---- dv/trp_host_model.sv ----
/*
 * Host side model of the result page: the serial master, seen after
 * its decoder, as command and data word strobes.
 * Assumes the bench calls its tasks and shares the page's clock.
 */
`timescale 1ns/10ps

module trp_host_model (
    // Clock
    input  wire logic        clock,
    // Strobes toward the page
    output logic             cmd_valid,
    output logic [15:0]      cmd_word,
    output logic             word_strobe,
    output logic [15:0]      write_word
);
    // ------------------------------------------------------------
    // Idle values at time zero
    // ------------------------------------------------------------
    initial begin
        cmd_valid   = 1'b0;
        cmd_word    = 16'h0000;
        word_strobe = 1'b0;
        write_word  = 16'h0000;
    end

    // One command word; a nonzero tail is only sent on purpose
    task automatic send_cmd(input logic dir, input logic [3:0] pg, input logic [5:0] off, input logic [4:0] tail);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_word  = {dir, pg, off, tail};
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_word  = ~cmd_word; // Stale word inverted so nothing leans on it
    endtask

    // One further word of the session
    task automatic send_word(input logic [15:0] w);
        @(negedge clock);
        word_strobe = 1'b1;
        write_word  = w;
        @(negedge clock);
        word_strobe = 1'b0;
        write_word  = ~w; // Released data does not keep its last value
    endtask
endmodule

// ---- include/trp_defs.svh ----
/*
 * Offsets, field positions, reset values and fill patterns of the
 * touch result register page.
 * Assumes inclusion by bare name from the include folder.
 */
`ifndef TRP_DEFS_SVH
`define TRP_DEFS_SVH

// ----------------------------------------------------------------
// Command word fields
// ----------------------------------------------------------------
`define TRP_CMD_DIR_BIT        15
`define TRP_CMD_PAGE_HI        14
`define TRP_CMD_PAGE_LO        11
`define TRP_CMD_OFFSET_HI      10
`define TRP_CMD_OFFSET_LO      5
`define TRP_CMD_RSVD_HI        4
`define TRP_CMD_RSVD_LO        0

// ----------------------------------------------------------------
// Page codes
// ----------------------------------------------------------------
`define TRP_PAGE_DATA          4'h0
`define TRP_PAGE_LAST_USED     4'h3

// ----------------------------------------------------------------
// Result register offsets on the data page
// ----------------------------------------------------------------
`define TRP_OFF_HORIZONTAL_POSITION_RESULT  6'h00
`define TRP_OFF_VERTICAL_POSITION_RESULT    6'h01
`define TRP_OFF_TOUCH_PRESSURE_ONE_RESULT   6'h02
`define TRP_OFF_TOUCH_PRESSURE_TWO_RESULT   6'h03
`define TRP_OFF_SUPPLY_CELL_VOLTAGE_RESULT  6'h05
`define TRP_OFF_AUXILIARY_INPUT_ONE_RESULT  6'h07
`define TRP_OFF_AUXILIARY_INPUT_TWO_RESULT  6'h08
`define TRP_OFF_THERMAL_SENSE_ONE_RESULT    6'h09
`define TRP_OFF_THERMAL_SENSE_TWO_RESULT    6'h0A
`define TRP_OFF_PAGE_END                    6'h3F

// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define TRP_RESULT_RESET       12'h000
`define TRP_READ_PAST_END      16'hFFFF
`define TRP_READ_RESERVED      16'h0000
`define TRP_UPPER_ZERO         4'h0
`define TRP_SLOTS              11

`endif

// ---- include/trp_pkg.sv ----
/*
 * Types of the touch result register page.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package trp_pkg;

    // Transfer direction latched from the command word
    typedef enum logic {
        TRP_DIR_WRITE,
        TRP_DIR_READ
    } trp_dir_e;

    // One stored conversion result
    typedef logic [11:0] trp_result_t;

endpackage

// ---- verilog/trp_result_page.sv ----
/*
 * Data page of result registers for the touch and auxiliary converter,
 * with the word pointer that serves serial read and write sessions.
 * Assumes a serial port decoder on the same clock hands over each
 * command word and each further data word as one-cycle strobes, and
 * that the converter presents each finished result with a strobe.
 */
`timescale 1ns/10ps
`include "trp_defs.svh"

module trp_result_page
    import trp_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset_n,
    // Converter side
    input  wire logic        conv_valid,
    input  wire logic [5:0]  conv_select,
    input  wire logic [11:0] conv_result,
    // Serial command decoder side
    input  wire logic        cmd_valid,
    input  wire logic [15:0] cmd_word,
    input  wire logic        word_strobe,
    input  wire logic [15:0] write_word,
    // Answers to the decoder
    output logic [15:0]      read_data,
    output logic             read_valid,
    output logic             page_hit,
    output logic             other_page,
    output logic             reserved_page,
    output logic             command_error
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    trp_result_t result_mem [0:`TRP_SLOTS-1];      // Stored results by offset
    trp_result_t next_result_mem [0:`TRP_SLOTS-1];
    trp_dir_e    dir;                              // Session direction
    trp_dir_e    next_dir;
    logic        active;                           // Session open on data page
    logic        next_active;
    logic [5:0]  ptr;                              // Word pointer
    logic [5:0]  next_ptr;
    logic        past_end;                         // Pointer ran off the page
    logic        next_past_end;
    logic [15:0] next_read_data;
    logic        next_read_valid;
    logic        next_page_hit;
    logic        next_other_page;
    logic        next_reserved_page;
    logic        next_command_error;

    // Command fields
    logic [3:0]  page_select_bits;
    logic [5:0]  register_offset_bits;
    logic [4:0]  cmd_tail;

    assign page_select_bits     = cmd_word[`TRP_CMD_PAGE_HI:`TRP_CMD_PAGE_LO];
    assign register_offset_bits = cmd_word[`TRP_CMD_OFFSET_HI:`TRP_CMD_OFFSET_LO];
    assign cmd_tail             = cmd_word[`TRP_CMD_RSVD_HI:`TRP_CMD_RSVD_LO];

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // True for offsets that hold a result; the gaps are reserved
    function automatic logic is_result(input logic [5:0] off);
        is_result = (off == `TRP_OFF_HORIZONTAL_POSITION_RESULT) ||
                    (off == `TRP_OFF_VERTICAL_POSITION_RESULT)   ||
                    (off == `TRP_OFF_TOUCH_PRESSURE_ONE_RESULT)  ||
                    (off == `TRP_OFF_TOUCH_PRESSURE_TWO_RESULT)  ||
                    (off == `TRP_OFF_SUPPLY_CELL_VOLTAGE_RESULT) ||
                    (off == `TRP_OFF_AUXILIARY_INPUT_ONE_RESULT) ||
                    (off == `TRP_OFF_AUXILIARY_INPUT_TWO_RESULT) ||
                    (off == `TRP_OFF_THERMAL_SENSE_ONE_RESULT)   ||
                    (off == `TRP_OFF_THERMAL_SENSE_TWO_RESULT);
    endfunction

    // Read strobe and write strobe of an open session
    logic rd_word;
    logic wr_word;
    // A command in the same cycle wins over the word, so the word is dropped
    assign rd_word = word_strobe && !cmd_valid && active && (dir == TRP_DIR_READ);
    assign wr_word = word_strobe && !cmd_valid && active && (dir == TRP_DIR_WRITE);

    // ----------------------------------------------------------------
    // Result storage
    // ----------------------------------------------------------------
    // Only the converter writes here; host write data is never routed in
    always_comb begin
        for (int i = 0; i < `TRP_SLOTS; i++) begin
            next_result_mem[i] = result_mem[i];
        end
        if (conv_valid && is_result(conv_select)) begin
            next_result_mem[conv_select[3:0]] = conv_result;
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < `TRP_SLOTS; i++) begin
            if (!reset_n) begin
                result_mem[i] <= `TRP_RESULT_RESET;
            end else begin
                result_mem[i] <= next_result_mem[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Session and pointer
    // ----------------------------------------------------------------
    // A new command always ends the session, even mid-stream; only a clean data page command opens a new one
    always_comb begin
        next_dir           = dir;
        next_active        = active;
        next_ptr           = ptr;
        next_past_end      = past_end;
        next_page_hit      = page_hit;
        next_other_page    = other_page;
        next_reserved_page = reserved_page;
        next_command_error = 1'b0;
        if (cmd_valid) begin
            // Nonzero tail makes the command void
            next_command_error = (cmd_tail != 5'h00);
            next_dir           = cmd_word[`TRP_CMD_DIR_BIT] ? TRP_DIR_READ : TRP_DIR_WRITE;
            next_ptr           = register_offset_bits;
            next_past_end      = 1'b0;
            // Only page zero belongs to this bank
            next_page_hit      = (page_select_bits == `TRP_PAGE_DATA);
            next_other_page    = (page_select_bits != `TRP_PAGE_DATA) &&
                                 (page_select_bits <= `TRP_PAGE_LAST_USED);
            next_reserved_page = (page_select_bits > `TRP_PAGE_LAST_USED);
            next_active        = (cmd_tail == 5'h00) &&
                                 (page_select_bits == `TRP_PAGE_DATA);
        end else if (rd_word || wr_word) begin
            // Stop at the last location, then flag the overrun
            if (ptr == `TRP_OFF_PAGE_END) begin
                next_past_end = 1'b1;
            end else begin
                next_ptr = ptr + 6'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            dir           <= TRP_DIR_WRITE;
            active        <= 1'b0;
            ptr           <= 6'h00;
            past_end      <= 1'b0;
            page_hit      <= 1'b0;
            other_page    <= 1'b0;
            reserved_page <= 1'b0;
            command_error <= 1'b0;
        end else begin
            dir           <= next_dir;
            active        <= next_active;
            ptr           <= next_ptr;
            past_end      <= next_past_end;
            page_hit      <= next_page_hit;
            other_page    <= next_other_page;
            reserved_page <= next_reserved_page;
            command_error <= next_command_error;
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Reads run apart from writes; write words only move the pointer
    always_comb begin
        next_read_valid = rd_word;
        next_read_data  = read_data;
        if (rd_word) begin
            if (past_end) begin
                next_read_data = `TRP_READ_PAST_END;
            end else if (is_result(ptr)) begin
                // Upper nibble forced low, value right-justified
                next_read_data = {`TRP_UPPER_ZERO, result_mem[ptr[3:0]]};
            end else begin
                next_read_data = `TRP_READ_RESERVED;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            read_data  <= 16'h0000;
            read_valid <= 1'b0;
        end else begin
            read_data  <= next_read_data;
            read_valid <= next_read_valid;
        end
    end

    // write_word is deliberately unused: the page is read-only

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_read_in_page;
        rd_word && !past_end && is_result(ptr) && !cmd_valid;
    endsequence

    sequence s_read_over;
        rd_word && past_end && !cmd_valid;
    endsequence

    AST_RESET_CLEAR: assert property (
        !$past(reset_n) |-> (result_mem[0] == 12'h000) && (result_mem[10] == 12'h000))
        else $error("result not cleared by reset");

    AST_CONV_STORE: assert property (
        (conv_valid && is_result(conv_select)) |=>
            result_mem[$past(conv_select[3:0])] == $past(conv_result))
        else $error("conversion not stored");

    AST_WRITE_IGNORED: assert property (
        (wr_word && !conv_valid && is_result(ptr)) |=>
            result_mem[$past(ptr[3:0])] == $past(result_mem[ptr[3:0]]))
        else $error("host write changed a result");

    AST_UPPER_ZERO: assert property (
        (read_valid && !$past(past_end)) |-> read_data[15:12] == 4'h0)
        else $error("upper bits not zero");

    AST_JUSTIFY: assert property (
        s_read_in_page |=> read_valid && read_data[11:0] == $past(result_mem[ptr[3:0]]))
        else $error("result misplaced in read word");

    AST_HOLD: assert property (
        (!conv_valid && $past(reset_n)) [*2] |-> $stable(result_mem[1]) && $stable(result_mem[9]))
        else $error("result changed without conversion");

    AST_CMD_FORMAT: assert property (
        (cmd_valid && cmd_tail != 5'h00) |=> command_error && !active)
        else $error("bad command tail accepted");

    AST_PAST_END: assert property (
        s_read_over |=> read_valid && read_data == 16'hFFFF)
        else $error("overrun word not all ones");

    AST_PTR_ADV: assert property (
        (rd_word && !cmd_valid && ptr != 6'h3F) |=> ptr == $past(ptr) + 6'h01 ##1 1'b1)
        else $error("pointer did not advance");

    AST_PAGE_DECODE: assert property (
        cmd_valid |=> page_hit == ($past(page_select_bits) == 4'h0) &&
                      reserved_page == ($past(page_select_bits) > 4'h3))
        else $error("page decode wrong");

    AST_RW_SPLIT: assert property (
        wr_word |=> !read_valid)
        else $error("write word produced read data");

    // ----------------------------------------------------------------
    // Session and page checks
    // ----------------------------------------------------------------
    // Last location of the page read in an open session
    sequence s_read_last;
        rd_word && ptr == `TRP_OFF_PAGE_END;
    endsequence

    // Clean command aimed at the data page
    sequence s_open_data;
        cmd_valid && cmd_tail == 5'h00 && page_select_bits == `TRP_PAGE_DATA;
    endsequence

    // Once the last word is out, the pointer parks and the fill takes over
    AST_OVERRUN_FLAG: assert property (
        s_read_last |=> past_end && ptr == `TRP_OFF_PAGE_END)
        else $error("overrun not flagged at page end");

    AST_SESSION_OPEN: assert property (
        s_open_data |=> active && !command_error && ptr == $past(register_offset_bits))
        else $error("clean data page command did not open a session");

    // Other pages and reserved codes must leave the page silent
    AST_IDLE_WORD: assert property (
        (word_strobe && !cmd_valid && !active) |=> !read_valid)
        else $error("word answered outside a session");

    AST_OTHER_DECODE: assert property (
        cmd_valid |=> other_page == (($past(page_select_bits) != 4'h0) && ($past(page_select_bits) <= 4'h3)))
        else $error("other page decode wrong");

    // Outputs come out of reset quiet, with a zero read word
    AST_RESET_OUTPUTS: assert property (
        !$past(reset_n) |-> !read_valid && !command_error && read_data == 16'h0000)
        else $error("outputs not cleared by reset");

endmodule
